// file: rtl/scsp_pkg.sv
// Package: register map, field layout, reset values and types for the pacing block.
// Assumes a 32-bit APB with word-aligned registers at four times the printed index.
package scsp_pkg;
  // ==========================================================================
  // Register indices and byte addresses
  localparam logic [7:0] IDX_SYNC_PERIOD  = 8'h06;
  localparam logic [7:0] IDX_FIFO_STEP    = 8'h07;
  localparam logic [7:0] IDX_SYNC_OFFSET  = 8'h07;
  localparam logic [7:0] IDX_FIRST_CONFIG = 8'h08;
  localparam logic [7:0] IDX_SEQ_CTRL     = 8'h10;
  localparam logic [7:0] IDX_TEST_CTRL    = 8'h11;
  localparam logic [11:0] ADDR_SYNC_PERIOD  = {2'h0, IDX_SYNC_PERIOD, 2'h0};
  localparam logic [11:0] ADDR_FIFO_STEP    = {2'h0, IDX_FIFO_STEP, 2'h0};
  localparam logic [11:0] ADDR_SYNC_OFFSET  = {2'h0, IDX_SYNC_OFFSET, 2'h0};
  localparam logic [11:0] ADDR_FIRST_CONFIG = {2'h0, IDX_FIRST_CONFIG, 2'h0};
  localparam logic [11:0] ADDR_SEQ_CTRL     = {2'h0, IDX_SEQ_CTRL, 2'h0};
  localparam logic [11:0] ADDR_TEST_CTRL    = {2'h0, IDX_TEST_CTRL, 2'h0};
  // ==========================================================================
  // Reset values and fields
  localparam logic [7:0] RST_SYNC_PERIOD  = 8'h05;
  localparam logic [7:0] RST_SYNC_OFFSET  = 8'h00;
  localparam logic [7:0] RST_FIRST_CONFIG = 8'h00;
  localparam int         PERIOD_W         = 5;
  localparam int         OFFSET_W         = 4;
  localparam int         COUNT_W          = 5;
  localparam int         BIT_SLOW_CABLE   = 7;
  localparam int         BIT_OFFSET_NZ    = 5;
  // ==========================================================================
  // Period decode constants
  localparam logic [4:0] PERIOD_LOW_LIMIT = 5'h04;
  localparam logic [4:0] PERIOD_MIN_FIX   = 5'h06;
  localparam logic [5:0] CLOCKS_MIN       = 6'h05;
  localparam logic [5:0] CLOCKS_WRAP_BASE = 6'h20;
  // ==========================================================================
  // Sequence step and interrupt codes
  localparam logic [2:0] STEP_0 = 3'h0;
  localparam logic [2:0] STEP_1 = 3'h1;
  localparam logic [2:0] STEP_2 = 3'h2;
  localparam logic [7:0] INT_DONE      = 8'h08;
  localparam logic [7:0] INT_DONE_ATN  = 8'h18;
  localparam logic [7:0] INT_DISC_DONE = 8'h28;

  typedef enum logic [2:0] {
    SCSP_SEQ_RECV_CMD,
    SCSP_SEQ_DISCONNECT,
    SCSP_SEQ_TERMINATE,
    SCSP_SEQ_CMD_COMPLETE
  } scsp_seq_t;

  typedef enum logic [1:0] {
    SCSP_ST_IDLE,
    SCSP_ST_DATA,
    SCSP_ST_STROBE
  } scsp_state_t;

  typedef struct packed {
    logic        valid;
    scsp_seq_t   seq;
    logic        parity_err;
    logic        atn;
    logic [1:0]  bytes_done;
  } scsp_seq_ev_t;

  typedef struct packed {
    logic [7:0]  period;
    logic [7:0]  offset;
    logic [7:0]  config1;
    logic        test_mode;
    logic [2:0]  step;
    logic [7:0]  int_val;
    logic        bus_free;
    scsp_state_t state;
    logic [5:0]  pace_cnt;
    logic [4:0]  outstanding;
    logic [4:0]  ack_owed;
    logic        strobe;
    logic [31:0] prdata;
  } scsp_state_s_t;
endpackage

// file: rtl/scsp_core.sv
// Synchronous pacing, offset control and sequence status for the SCSI controller device.
// Assumes APB master on i_clk_sys; FIFO count and sequence events come from the core.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Parity stop in command: step 1, code 08/18
// - Full CDB without ATN: step 2, code 08
// - Full CDB with ATN: step 2, code 18
// - Disconnect ATN stop: step 0/1, code 18
// - Disconnect done: bus free, step 2, 28
// - Terminate/complete ATN stop: step 0/1, 18
// - Terminate done: bus free, step 2, 28
// - Command complete done: step 2, code 08
// - Low five period bits set strobe spacing
// - Period decode with 5 minimum, 32-35 wrap
// - Resets load period with five
// - FIFO status low bits give byte count
// - Top status bits mirror sequence step
// - Test mode bit 5 shows offset not yet reached
// - Low four offset bits, zero means asynchronous
// - Stop sending at offset, one per ack
// - One acknowledge per byte drained
// - Resets clear synchronous offset
// - First configuration reads back as written
// - Slow cable inserts one extra clock
module scsp_core (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_nrst,
  input  wire logic                  i_clk_en,
  input  wire logic                  i_soft_reset,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [11:0]           i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic                       o_pready,
  output logic [31:0]                o_prdata,
  output logic                       o_pslverr,
  input  wire scsp_pkg::scsp_seq_ev_t i_seq_ev,
  input  wire logic [4:0]            i_fifo_byte_count,
  input  wire logic                  i_xfer_send,
  input  wire logic                  i_send_req,
  input  wire logic                  i_ack_in,
  input  wire logic                  i_fifo_drain,
  output logic                       o_data_drive,
  output logic                       o_strobe,
  output logic                       o_send_block,
  output logic                       o_sync_mode,
  output logic [2:0]                 o_seq_step,
  output logic [7:0]                 o_int_val,
  output logic                       o_bus_free
);
  scsp_pkg::scsp_state_s_t s_q;
  scsp_pkg::scsp_state_s_t s_d;
  logic [5:0] clocks_per_byte;
  logic [3:0] sync_off;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;
  logic       can_send;
  logic       ack_dec;

  // ==========================================================================
  // Period decode and offset
  always_comb begin
    if (s_q.period[4:0] < scsp_pkg::PERIOD_LOW_LIMIT) begin
      clocks_per_byte = scsp_pkg::CLOCKS_WRAP_BASE + {4'h0, s_q.period[1:0]};
    end else if (s_q.period[4:0] < scsp_pkg::PERIOD_MIN_FIX) begin
      clocks_per_byte = scsp_pkg::CLOCKS_MIN;
    end else begin
      clocks_per_byte = {1'b0, s_q.period[4:0]};
    end
  end

  assign sync_off     = s_q.offset[3:0];
  assign o_sync_mode  = (sync_off != 4'h0);
  // Strobe held off while offset exhausted; the acknowledge frees a slot
  assign ack_dec      = i_ack_in && (s_q.outstanding != 5'h00);
  assign o_send_block = o_sync_mode && ({1'b0, sync_off} == s_q.outstanding);
  assign can_send     = i_xfer_send && i_send_req && !o_send_block;

  // ==========================================================================
  // APB decode
  assign addr_ok   = (i_paddr == scsp_pkg::ADDR_SYNC_PERIOD)
                  || (i_paddr == scsp_pkg::ADDR_FIFO_STEP)
                  || (i_paddr == scsp_pkg::ADDR_FIRST_CONFIG)
                  || (i_paddr == scsp_pkg::ADDR_SEQ_CTRL)
                  || (i_paddr == scsp_pkg::ADDR_TEST_CTRL);
  assign wr_en     = i_clk_en && i_psel && i_penable && i_pwrite;
  // Read data captured in setup, so it already stands when pready is sampled
  assign rd_en     = i_clk_en && i_psel && !i_penable && !i_pwrite;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.strobe = 1'b0;
    // Registers
    if (wr_en) begin
      case (i_paddr)
        scsp_pkg::ADDR_SYNC_PERIOD:  s_d.period  = i_pwdata[7:0];
        scsp_pkg::ADDR_SYNC_OFFSET:  s_d.offset  = i_pwdata[7:0];
        scsp_pkg::ADDR_FIRST_CONFIG: s_d.config1 = i_pwdata[7:0];
        scsp_pkg::ADDR_TEST_CTRL:    s_d.test_mode = i_pwdata[0];
        default: ;
      endcase
    end
    if (rd_en) begin
      case (i_paddr)
        scsp_pkg::ADDR_FIFO_STEP: begin
          s_d.prdata = {24'h0, s_q.step, i_fifo_byte_count};
          if (s_q.test_mode) begin
            s_d.prdata[scsp_pkg::BIT_OFFSET_NZ] = (s_q.outstanding != {1'b0, sync_off});
          end
        end
        scsp_pkg::ADDR_FIRST_CONFIG: s_d.prdata = {24'h0, s_q.config1};
        scsp_pkg::ADDR_SEQ_CTRL:     s_d.prdata = {23'h0, s_q.bus_free, s_q.int_val};
        scsp_pkg::ADDR_TEST_CTRL:    s_d.prdata = {31'h0, s_q.test_mode};
        default:                     s_d.prdata = 32'h0;
      endcase
    end
    // Sequence status
    if (i_seq_ev.valid) begin
      s_d.bus_free = 1'b0;
      case (i_seq_ev.seq)
        scsp_pkg::SCSP_SEQ_RECV_CMD: begin
          s_d.step    = i_seq_ev.parity_err ? scsp_pkg::STEP_1 : scsp_pkg::STEP_2;
          s_d.int_val = i_seq_ev.atn ? scsp_pkg::INT_DONE_ATN : scsp_pkg::INT_DONE;
        end
        scsp_pkg::SCSP_SEQ_DISCONNECT, scsp_pkg::SCSP_SEQ_TERMINATE: begin
          if (i_seq_ev.atn) begin
            s_d.step    = (i_seq_ev.bytes_done == 2'h1) ? scsp_pkg::STEP_0 : scsp_pkg::STEP_1;
            s_d.int_val = scsp_pkg::INT_DONE_ATN;
          end else begin
            s_d.step     = scsp_pkg::STEP_2;
            s_d.int_val  = scsp_pkg::INT_DISC_DONE;
            s_d.bus_free = 1'b1;
          end
        end
        scsp_pkg::SCSP_SEQ_CMD_COMPLETE: begin
          if (i_seq_ev.atn) begin
            s_d.step    = (i_seq_ev.bytes_done == 2'h1) ? scsp_pkg::STEP_0 : scsp_pkg::STEP_1;
            s_d.int_val = scsp_pkg::INT_DONE_ATN;
          end else begin
            s_d.step    = scsp_pkg::STEP_2;
            s_d.int_val = scsp_pkg::INT_DONE;
          end
        end
        default: ;
      endcase
    end
    // Pacing counter
    if (s_q.pace_cnt != 6'h00) begin
      s_d.pace_cnt = s_q.pace_cnt - 6'h01;
    end
    case (s_q.state)
      scsp_pkg::SCSP_ST_IDLE: begin
        if (can_send && s_q.pace_cnt <= 6'h01) begin
          // Slow cable: data driven two clocks before the strobe instead of one
          s_d.state = s_q.config1[scsp_pkg::BIT_SLOW_CABLE] ?
                      scsp_pkg::SCSP_ST_DATA : scsp_pkg::SCSP_ST_STROBE;
        end
      end
      scsp_pkg::SCSP_ST_DATA:   s_d.state = scsp_pkg::SCSP_ST_STROBE;
      scsp_pkg::SCSP_ST_STROBE: begin
        s_d.strobe   = 1'b1;
        s_d.pace_cnt = clocks_per_byte - 6'h01;
        s_d.state    = scsp_pkg::SCSP_ST_IDLE;
      end
      default: s_d.state = scsp_pkg::SCSP_ST_IDLE;
    endcase
    // Receive side: each drained byte owes an acknowledge strobe
    if (!i_xfer_send && o_sync_mode) begin
      // No staging state here, so wait for a fully expired count
      if (s_q.ack_owed != 5'h00 && s_q.pace_cnt == 6'h00 && !s_q.strobe) begin
        s_d.strobe   = 1'b1;
        s_d.pace_cnt = clocks_per_byte - 6'h01;
        s_d.ack_owed = s_q.ack_owed - 5'h01 + {4'h0, i_fifo_drain};
      end else if (i_fifo_drain) begin
        s_d.ack_owed = s_q.ack_owed + 5'h01;
      end
    end
    // Outstanding counter on send
    if (i_xfer_send && o_sync_mode) begin
      if (s_d.strobe && !ack_dec) begin
        s_d.outstanding = s_q.outstanding + 5'h01;
      end else if (!s_d.strobe && ack_dec) begin
        s_d.outstanding = s_q.outstanding - 5'h01;
      end
    end
    // Chip reset keeps configuration semantics of hard reset
    if (i_soft_reset) begin
      s_d.period      = scsp_pkg::RST_SYNC_PERIOD;
      s_d.offset      = scsp_pkg::RST_SYNC_OFFSET;
      s_d.config1     = scsp_pkg::RST_FIRST_CONFIG;
      s_d.test_mode   = 1'b0;
      s_d.outstanding = 5'h00;
      s_d.ack_owed    = 5'h00;
      s_d.state       = scsp_pkg::SCSP_ST_IDLE;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q             <= '0;
      s_q.period      <= scsp_pkg::RST_SYNC_PERIOD;
      s_q.offset      <= scsp_pkg::RST_SYNC_OFFSET;
      s_q.config1     <= scsp_pkg::RST_FIRST_CONFIG;
      s_q.state       <= scsp_pkg::SCSP_ST_IDLE;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_prdata     = s_q.prdata;
  assign o_strobe     = s_q.strobe;
  assign o_data_drive = (s_q.state != scsp_pkg::SCSP_ST_IDLE) || s_q.strobe;
  assign o_seq_step   = s_q.step;
  assign o_int_val    = s_q.int_val;
  assign o_bus_free   = s_q.bus_free;
endmodule
`default_nettype wire

// file: verif/scsp_chk.sv
// Checker: port-level properties of sequence status and strobe pacing.
// Assumes bind from the bench top; i_clk_en is dropped only while the link is idle.
`timescale 1ns/1ps
`default_nettype none
module scsp_chk (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_nrst,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire scsp_pkg::scsp_seq_ev_t i_seq_ev,
  input  wire logic                   o_pslverr,
  input  wire logic                   o_strobe,
  input  wire logic                   o_send_block,
  input  wire logic                   o_sync_mode,
  input  wire logic [2:0]             o_seq_step,
  input  wire logic [7:0]             o_int_val,
  input  wire logic                   o_bus_free
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  wire logic       rcv  = i_seq_ev.valid && i_seq_ev.seq == scsp_pkg::SCSP_SEQ_RECV_CMD;
  wire logic       fin  = i_seq_ev.valid && i_seq_ev.seq != scsp_pkg::SCSP_SEQ_RECV_CMD;
  wire logic       cc   = i_seq_ev.seq == scsp_pkg::SCSP_SEQ_CMD_COMPLETE;
  wire logic [7:0] code = i_seq_ev.atn ? 8'h18 : 8'h08;
  AST_RECV_PAR: assert property (rcv && i_seq_ev.parity_err
    |=> o_seq_step == 3'h1 && o_int_val == $past(code)) else $error("parity stop status wrong");
  AST_RECV_FULL: assert property (rcv && !i_seq_ev.parity_err
    |=> o_seq_step == 3'h2 && o_int_val == $past(code)) else $error("full command status wrong");
  AST_ATN_STOP: assert property (fin && i_seq_ev.atn |=> o_int_val == 8'h18
    && o_seq_step == ($past(i_seq_ev.bytes_done) == 2'h1 ? 3'h0 : 3'h1))
    else $error("attention stop status wrong");
  AST_DISC_DONE: assert property (fin && !i_seq_ev.atn && !cc
    |=> o_seq_step == 3'h2 && o_int_val == 8'h28 && o_bus_free) else $error("disconnect status wrong");
  AST_CC_DONE: assert property (fin && !i_seq_ev.atn && cc
    |=> o_seq_step == 3'h2 && o_int_val == 8'h08) else $error("complete status wrong");
  AST_PACE_MIN: assert property (o_strobe |=> !o_strobe [*4])
    else $error("strobes closer than five clocks");
  AST_BLOCK_SYNC: assert property (o_send_block |-> o_sync_mode)
    else $error("send blocked outside synchronous mode");
  AST_SLVERR: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("slave error outside access phase");
endmodule
`default_nettype wire

// file: verif/scsp_partner.sv
// Partner: far-side device returning one acknowledge per strobe.
// Assumes one-cycle strobes; i_stall models a receiver holding back.
`timescale 1ns/1ps
`default_nettype none
module scsp_partner (
  input  wire logic i_clk_sys,
  input  wire logic i_nrst,
  input  wire logic i_strobe,
  input  wire logic i_stall,
  output logic      o_ack
);
  logic [4:0] owed_q;
  // Idle cycle between acks keeps each one a distinct pulse
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      owed_q <= 5'h00;
      o_ack  <= 1'b0;
    end else begin
      owed_q <= owed_q + {4'h0, i_strobe} - {4'h0, o_ack};
      o_ack  <= !i_stall && owed_q != 5'h00 && !o_ack;
    end
  end
endmodule
`default_nettype wire

// file: verif/scsp_core_test.sv
// Bench: APB-driven checks of status codes, pacing, offset and readback.
// Assumes the package, core, partner and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module scsp_core_test;
  logic                   clk = 1'b0;
  logic                   nrst = 1'b0;
  logic                   srst = 1'b0;
  logic                   psel = 1'b0;
  logic                   pen = 1'b0;
  logic                   pwr = 1'b0;
  logic [11:0]            paddr = 12'h000;
  logic [31:0]            pwdata = 32'h0;
  scsp_pkg::scsp_seq_ev_t ev = '0;
  logic [4:0]             fcnt = 5'h00;
  logic                   xsend = 1'b1;
  logic                   sreq = 1'b0;
  logic                   drain = 1'b0;
  logic                   stall = 1'b0;
  logic                   cen = 1'b1;
  logic                   pready, pslverr, ack, strobe, blk, sync, free, err, drv;
  logic                   lead = 1'b0;
  logic [1:0]             drv_q = 2'h0;
  logic [31:0]            prdata, rd, n0;
  logic [31:0]            cyc = 32'h0, last = 32'h0, gap = 32'h0, nstb = 32'h0;
  logic [2:0]             step;
  logic [7:0]             intv;
  int                     bad_count = 0;
  int                     checks_done = 0;
  // Rows: seq, {parity, atn, bytes}, step, code
  logic [19:0] evt [11] = '{20'h08108, 20'h0C118, 20'h00208, 20'h04218, 20'h15018,
    20'h16118, 20'h10228, 20'h25018, 20'h36118, 20'h20228, 20'h30208};
  // Rows: period written, clocks per byte; first row is the reset value
  logic [15:0] per [7] = '{16'hFF05, 16'h0405, 16'h0505, 16'h1F1F, 16'h0020, 16'h0323, 16'hE606};
  always #5 clk = ~clk;
  scsp_core dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_clk_en(cen), .i_soft_reset(srst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_seq_ev(ev),
    .i_fifo_byte_count(fcnt), .i_xfer_send(xsend), .i_send_req(sreq), .i_ack_in(ack),
    .i_fifo_drain(drain), .o_data_drive(drv), .o_strobe(strobe), .o_send_block(blk),
    .o_sync_mode(sync), .o_seq_step(step), .o_int_val(intv), .o_bus_free(free));
  scsp_partner far_u (.i_clk_sys(clk), .i_nrst(nrst), .i_strobe(strobe), .i_stall(stall),
    .o_ack(ack));
  always_ff @(posedge clk) begin
    cyc   <= cyc + 32'h1;
    drv_q <= {drv_q[0], drv};
    if (strobe) begin
      // Data driven two cycles ahead of the strobe only with slow cable
      lead <= drv_q[1];
      gap  <= cyc - last;
      last <= cyc;
      nstb <= nstb + 32'h1;
    end
  end
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Request stands until pready is seen high; data and error taken there
    do @(posedge clk); while (pready !== 1'b1);
    rd   = prdata;
    err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    // Idle cycle keeps back-to-back calls from driving psel twice at once
    @(posedge clk);
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (evt[k]) begin
      ev   <= scsp_pkg::scsp_seq_ev_t'({1'b1, evt[k][18:12]});
      fcnt <= 5'(k + 20);
      @(posedge clk);
      ev.valid <= 1'b0;
      @(posedge clk);
      check("seq_step", {29'h0, step}, {29'h0, evt[k][10:8]});
      check("int_val", {24'h0, intv}, {24'h0, evt[k][7:0]});
      if (evt[k][7:0] == 8'h28) check("bus_free", {31'h0, free}, 32'h1);
      bus(1'b0, scsp_pkg::ADDR_FIFO_STEP, 32'h0);
      check("fifo_step", rd, {24'h0, evt[k][10:8], 5'(k + 20)});
    end
    $display("test status done");
    bus(1'b1, scsp_pkg::ADDR_SYNC_OFFSET, 32'h0F);
    check("sync_mode", {31'h0, sync}, 32'h1);
    foreach (per[k]) begin
      if (k > 0) bus(1'b1, scsp_pkg::ADDR_SYNC_PERIOD, {24'h0, per[k][15:8]});
      sreq <= 1'b1;
      repeat (80) @(posedge clk);
      check("pace_gap", gap, {24'h0, per[k][7:0]});
      check("plain_lead", {31'h0, lead}, 32'h0);
      sreq <= 1'b0;
      repeat (40) @(posedge clk);
    end
    $display("test pacing done");
    stall <= 1'b1;
    bus(1'b1, scsp_pkg::ADDR_TEST_CTRL, 32'h1);
    bus(1'b1, scsp_pkg::ADDR_SYNC_OFFSET, 32'hF3);
    bus(1'b0, scsp_pkg::ADDR_FIFO_STEP, 32'h0);
    check("offset_room", {31'h0, rd[5]}, 32'h1);
    n0 = nstb;
    sreq <= 1'b1;
    repeat (100) @(posedge clk);
    check("sent_at_offset", nstb - n0, 32'h3);
    check("send_block", {31'h0, blk}, 32'h1);
    bus(1'b0, scsp_pkg::ADDR_FIFO_STEP, 32'h0);
    check("offset_spent", {31'h0, rd[5]}, 32'h0);
    stall <= 1'b0;
    repeat (100) @(posedge clk);
    check("resumed", {31'h0, nstb - n0 > 32'h8}, 32'h1);
    sreq  <= 1'b0;
    stall <= 1'b1;
    xsend <= 1'b0;
    repeat (40) @(posedge clk);
    n0 = nstb;
    repeat (3) begin
      drain <= 1'b1;
      @(posedge clk);
      drain <= 1'b0;
      @(posedge clk);
    end
    repeat (60) @(posedge clk);
    check("recv_acks", nstb - n0, 32'h3);
    // Frozen clock enable must swallow drains and strobes alike
    cen   <= 1'b0;
    drain <= 1'b1;
    repeat (20) @(posedge clk);
    drain <= 1'b0;
    cen   <= 1'b1;
    @(posedge clk);
    check("frozen", nstb - n0, 32'h3);
    $display("test offset done");
    bus(1'b1, scsp_pkg::ADDR_FIRST_CONFIG, 32'hA5);
    bus(1'b0, scsp_pkg::ADDR_FIRST_CONFIG, 32'h0);
    check("config1", rd, 32'hA5);
    stall <= 1'b0;
    xsend <= 1'b1;
    sreq  <= 1'b1;
    repeat (80) @(posedge clk);
    check("slow_gap", gap, 32'h7);
    check("slow_lead", {31'h0, lead}, 32'h1);
    sreq <= 1'b0;
    repeat (40) @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check("offset_cleared", {31'h0, sync}, 32'h0);
    sreq <= 1'b1;
    repeat (40) @(posedge clk);
    check("period_reset", gap, 32'h5);
    sreq <= 1'b0;
    bus(1'b0, 12'h03C, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    $display("test registers done");
    wrap_up();
  end
endmodule
bind scsp_core scsp_chk chk_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_psel(i_psel),
  .i_penable(i_penable), .i_seq_ev(i_seq_ev), .o_pslverr(o_pslverr), .o_strobe(o_strobe),
  .o_send_block(o_send_block), .o_sync_mode(o_sync_mode), .o_seq_step(o_seq_step),
  .o_int_val(o_int_val), .o_bus_free(o_bus_free));
`default_nettype wire
